// >>> common/disk_cmd_pkg.sv
package disk_cmd_pkg;

   // Command phases
   typedef enum logic [2:0] {
      PH_COMMAND = 3'b001,
      PH_EXEC    = 3'b010,
      PH_RESULT  = 3'b100
   } phase_t;

   typedef enum logic [3:0] {
      K_INVALID   = 4'h0,
      K_READ      = 4'h1,
      K_WRITE     = 4'h2,
      K_FORMAT    = 4'h3,
      K_VERIFY    = 4'h4,
      K_SEEK      = 4'h5,
      K_REL_SEEK  = 4'h6,
      K_RECAL     = 4'h7,
      K_SENSE_INT = 4'h8,
      K_SPECIFY   = 4'h9,
      K_CONFIGURE = 4'ha,
      K_PERP      = 4'hb
   } cmd_kind_t;

   // Sector data path modes
   typedef enum logic [1:0] {
      M_READ   = 2'h0,
      M_WRITE  = 2'h1,
      M_FORMAT = 2'h2
   } gate_mode_t;

   // Opcode byte layout
   localparam logic [4:0] OP_READ      = 5'h06;
   localparam logic [4:0] OP_WRITE     = 5'h05;
   localparam logic [4:0] OP_FORMAT    = 5'h0d;
   localparam logic [4:0] OP_VERIFY    = 5'h16;
   localparam logic [4:0] OP_SEEK      = 5'h0f;
   localparam logic [4:0] OP_RECAL     = 5'h07;
   localparam logic [4:0] OP_SENSE_INT = 5'h08;
   localparam logic [4:0] OP_SPECIFY   = 5'h03;
   localparam logic [4:0] OP_CONFIGURE = 5'h13;
   localparam logic [4:0] OP_PERP      = 5'h12;
   localparam logic [7:0] OP_REL_SEEK_MASK = 8'hbf;
   localparam logic [7:0] OP_REL_SEEK      = 8'h8f;
   localparam int         DIR_BIT          = 6;
   localparam int         EC_BIT           = 7;
   localparam int         HEAD_BIT         = 2;

   // Parameter byte counts
   localparam logic [3:0] NPAR_RW   = 4'h8;
   localparam logic [3:0] NPAR_FMT  = 4'h5;
   localparam logic [3:0] NPAR_SEEK = 4'h2;
   localparam logic [3:0] NPAR_ONE  = 4'h1;
   localparam logic [3:0] NPAR_SPEC = 4'h2;
   localparam logic [3:0] NPAR_CONF = 4'h3;
   localparam logic [3:0] NPAR_NONE = 4'h0;

   // Configure and perpendicular-mode byte fields
   localparam int EIS_BIT   = 6;
   localparam int QUEUE_ENABLE_N_BIT = 5;
   localparam int THR_LSB   = 0;
   localparam int THR_MSB   = 3;
   localparam int PERP_LSB  = 2;
   localparam int PERP_MSB  = 5;

   // Reset values and status codes
   localparam logic       QUEUE_EN_N_RST = 1'b1;
   localparam logic [3:0] THR_RST        = 4'h0;
   localparam logic [7:0] ST0_INVALID    = 8'h80;
   localparam logic [7:0] ST0_NORMAL     = 8'h00;

   // Sector length: 128 << size code
   localparam int         SECT_BASE_LOG2 = 7;
   localparam int         SECT_CNT_W     = 15;

   typedef struct packed {
      logic [1:0] unit;
      logic       head;
      logic [7:0] cylinder;
      logic [7:0] sector;
      logic [2:0] size_code;
      logic [7:0] last_sector_number;
      logic [7:0] gap_len;
      logic [7:0] special_length;
      logic [7:0] sectors_per_track;
      logic [7:0] fill_pattern;
      logic       step_inward;
      logic       count_enable;
   } cmd_params_t;

   typedef struct packed {
      logic       queue_enable_n;
      logic       implied_seek_enable;
      logic [3:0] fifo_threshold;
      logic [3:0] vertical_drive_flags;
   } disk_config_t;

endpackage

// >>> src/sector_byte_gate.sv
`timescale 1ns/1ps
module sector_byte_gate
   import disk_cmd_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_start,
   input  wire logic       i_byte_strobe,
   input  gate_mode_t      i_mode,
   input  wire logic [2:0] i_size_code,
   input  wire logic [7:0] i_special_length,
   input  wire logic [7:0] i_fill_pattern,
   input  wire logic [7:0] i_host_byte,
   output logic [7:0]      o_disk_byte,
   output logic            o_host_pass,
   output logic            o_crc_take,
   output logic            o_sector_end
);
   import disk_cmd_pkg::*;

   logic [SECT_CNT_W-1:0] pos_q;
   logic [SECT_CNT_W-1:0] pos_d;
   logic [SECT_CNT_W-1:0] phys_len;
   logic [SECT_CNT_W-1:0] host_len;
   logic                  last_byte;
   logic                  in_host;
   logic [7:0]            byte_d;

   // Shift sum needs four bits: code 7 plus 7 is 14
   assign phys_len = SECT_CNT_W'(1) << (4'(i_size_code) + 4'(SECT_BASE_LOG2));
   // Code zero takes the special length, else it is ignored
   assign host_len = (i_size_code == 3'h0) ? SECT_CNT_W'(i_special_length)
                                            : phys_len;
   assign last_byte = (pos_q == phys_len - SECT_CNT_W'(1));
   assign in_host   = (pos_q < host_len);
   assign pos_d     = (i_start || (i_byte_strobe && last_byte)) ? '0
                    : (i_byte_strobe ? pos_q + SECT_CNT_W'(1) : pos_q);
   assign byte_d    = (i_mode == M_FORMAT) ? i_fill_pattern
                    : (in_host ? i_host_byte : 8'h00);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_q        <= '0;
         o_disk_byte  <= 8'h00;
         o_host_pass  <= 1'b0;
         o_crc_take   <= 1'b0;
         o_sector_end <= 1'b0;
      end else begin
         pos_q        <= pos_d;
         o_disk_byte  <= byte_d;
         // Whole sector is read, only the host part is passed on
         o_host_pass  <= i_byte_strobe && in_host && (i_mode == M_READ);
         o_crc_take   <= i_byte_strobe;
         o_sector_end <= i_byte_strobe && last_byte;
      end
   end
endmodule

// >>> src/disk_cmd_param_decoder.sv
`timescale 1ns/1ps
// Functional notes
// - Command bytes are taken only in the command phase with request flag up.
// - First byte is opcode-checked; bad opcode raises the interrupt.
// - After a bad opcode, sense-interrupt reports the invalid-command status.
// - Cylinder is a full eight-bit value, 0 through 255.
// - Format writes the fill pattern into every data field.
// - One vertical-recording flag per drive, one means perpendicular.
// - Relative seek direction: zero steps outward, one steps inward.
// - Two unit-select bits decode to drive 0 to 3.
// - Size code zero: special length sets host byte count.
// - Short reads fetch the whole sector but pass only the host part.
// - Short writes pad the sector remainder with zero bytes.
// - CRC covers every physical byte of the sector.
// - Nonzero size code ignores the special length; host should send FF.
// - Count enable turns the verify length slot into sectors per track.
// - Queue enable is active low and resets to disabled.
// - Implied seek precedes read or write commands carrying a cylinder.
// - Last sector number ends the transfer on the track.
// - Sector length is 128 times two to the size code, codes 0 to 7.
module disk_cmd_param_decoder
   import disk_cmd_pkg::*;
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_cmd_wr,
   input  wire logic [7:0]          i_cmd_byte,
   input  wire logic                i_exec_done,
   input  wire logic                i_result_done,
   input  wire logic                i_byte_strobe,
   input  wire logic [7:0]          i_host_byte,
   output logic                     o_request_for_master,
   output logic                     o_transfer_direction_flag,
   output logic                     o_cmd_busy,
   output logic                     o_irq,
   output logic                     o_exec_start,
   output disk_cmd_pkg::cmd_kind_t  o_cmd_kind,
   output disk_cmd_pkg::cmd_params_t o_params,
   output disk_cmd_pkg::disk_config_t o_config,
   output logic                     o_seek_first,
   output logic [7:0]               o_sense_status,
   output logic [3:0]               o_drive_select,
   output logic [7:0]               o_disk_byte,
   output logic                     o_host_pass,
   output logic                     o_crc_take,
   output logic                     o_sector_end
);
   import disk_cmd_pkg::*;

   // Opcode check: anything unlisted is invalid
   function automatic cmd_kind_t decode_op(input logic [7:0] b);
      cmd_kind_t k;
      k = K_INVALID;
      if ((b & OP_REL_SEEK_MASK) == OP_REL_SEEK) begin
         k = K_REL_SEEK;
      end else begin
         case (b[4:0])
            OP_READ:      k = K_READ;
            OP_WRITE:     k = K_WRITE;
            OP_FORMAT:    k = K_FORMAT;
            OP_VERIFY:    k = K_VERIFY;
            OP_SEEK:      k = (b[7:5] == 3'h0) ? K_SEEK : K_INVALID;
            OP_RECAL:     k = K_RECAL;
            OP_SENSE_INT: k = K_SENSE_INT;
            OP_SPECIFY:   k = K_SPECIFY;
            OP_CONFIGURE: k = K_CONFIGURE;
            OP_PERP:      k = K_PERP;
            default:      k = K_INVALID;
         endcase
      end
      return k;
   endfunction

   function automatic logic [3:0] param_count(input cmd_kind_t k);
      logic [3:0] n;
      n = NPAR_NONE;
      case (k)
         K_READ, K_WRITE, K_VERIFY: n = NPAR_RW;
         K_FORMAT:                  n = NPAR_FMT;
         K_SEEK, K_REL_SEEK:        n = NPAR_SEEK;
         K_RECAL, K_PERP:           n = NPAR_ONE;
         K_SPECIFY:                 n = NPAR_SPEC;
         K_CONFIGURE:               n = NPAR_CONF;
         default:                   n = NPAR_NONE;
      endcase
      return n;
   endfunction

   // Binary unit number to one-hot drive line
   function automatic logic [3:0] unit_onehot(input logic [1:0] u);
      return 4'h1 << u;
   endfunction

   // Next phase once all bytes of a command are in
   function automatic phase_t phase_after_cmd(input cmd_kind_t k);
      phase_t p;
      case (k)
         K_SENSE_INT:                     p = PH_RESULT;
         K_SPECIFY, K_CONFIGURE, K_PERP:  p = PH_COMMAND;
         default:                         p = PH_EXEC;
      endcase
      return p;
   endfunction

   phase_t       phase_q;
   phase_t       phase_d;
   cmd_kind_t    kind_q;
   cmd_kind_t    kind_d;
   logic [3:0]   idx_q;
   logic [3:0]   idx_d;
   logic [3:0]   need_q;
   logic [3:0]   need_d;
   cmd_params_t  par_q;
   cmd_params_t  par_d;
   disk_config_t cfg_q;
   disk_config_t cfg_d;
   logic         invalid_pend_q;
   logic         invalid_pend_d;
   logic         rqm_q;
   logic         irq_q;
   logic         irq_d;
   logic         start_q;
   logic         seek_first_q;
   logic [7:0]   sense_q;
   logic [7:0]   sense_d;

   logic         in_cmd;
   logic         take;
   logic         take_op;
   logic         take_par;
   cmd_kind_t    new_kind;
   logic [3:0]   new_need;
   logic         op_bad;
   logic         last_par;
   logic         op_only;
   logic         cmd_complete;
   cmd_kind_t    done_kind;
   logic         has_cyl;
   gate_mode_t   gate_mode;

   // Writes outside the command phase or while processing are dropped
   assign in_cmd   = (phase_q == PH_COMMAND);
   assign take     = i_cmd_wr && in_cmd && rqm_q;
   assign take_op  = take && (idx_q == 4'h0);
   assign take_par = take && (idx_q != 4'h0);
   assign new_kind = decode_op(i_cmd_byte);
   assign new_need = param_count(new_kind);
   assign op_bad   = take_op && (new_kind == K_INVALID);
   assign op_only  = take_op && !op_bad && (new_need == NPAR_NONE);
   assign last_par = take_par && (idx_q == need_q);
   assign cmd_complete = op_only || last_par;
   assign done_kind    = op_only ? new_kind : kind_q;
   assign has_cyl  = (done_kind == K_READ) || (done_kind == K_WRITE);

   // Byte index and phase sequencing
   always_comb begin
      phase_d = phase_q;
      kind_d  = kind_q;
      idx_d   = idx_q;
      need_d  = need_q;
      case (phase_q)
         PH_COMMAND: begin
            if (take_op && !op_bad) begin
               kind_d = new_kind;
               need_d = new_need;
               idx_d  = 4'h1;
            end
            if (cmd_complete) begin
               idx_d   = 4'h0;
               phase_d = phase_after_cmd(done_kind);
            end else if (take_par) begin
               idx_d = idx_q + 4'h1;
            end
         end
         PH_EXEC: begin
            if (i_exec_done) begin
               phase_d = ((kind_q == K_SEEK) || (kind_q == K_REL_SEEK) ||
                          (kind_q == K_RECAL)) ? PH_COMMAND : PH_RESULT;
            end
         end
         PH_RESULT: begin
            if (i_result_done) begin
               phase_d = PH_COMMAND;
            end
         end
         default: begin
            phase_d = PH_COMMAND;
            idx_d   = 4'h0;
         end
      endcase
   end

   // Invalid opcode interrupt and its sense report
   always_comb begin
      irq_d          = irq_q;
      invalid_pend_d = invalid_pend_q;
      sense_d        = sense_q;
      if (op_only && (new_kind == K_SENSE_INT)) begin
         sense_d        = invalid_pend_q ? ST0_INVALID : ST0_NORMAL;
         invalid_pend_d = 1'b0;
         irq_d          = 1'b0;
      end
      // A new bad opcode wins over any clear
      if (op_bad) begin
         irq_d          = 1'b1;
         invalid_pend_d = 1'b1;
      end
      if ((phase_q == PH_EXEC) && i_exec_done) begin
         irq_d = 1'b1;
      end
   end

   // Field capture; held until the next command overwrites them
   always_comb begin
      par_d = par_q;
      cfg_d = cfg_q;
      if (take_op && !op_bad) begin
         par_d.step_inward = i_cmd_byte[DIR_BIT];
      end
      if (take_par) begin
         case (kind_q)
            K_READ, K_WRITE, K_VERIFY: begin
               case (idx_q)
                  4'h1: begin
                     par_d.unit         = i_cmd_byte[1:0];
                     par_d.head         = i_cmd_byte[HEAD_BIT];
                     par_d.count_enable = (kind_q == K_VERIFY) &&
                                          i_cmd_byte[EC_BIT];
                  end
                  4'h2: par_d.cylinder  = i_cmd_byte;
                  4'h3: par_d.head      = i_cmd_byte[0];
                  4'h4: par_d.sector    = i_cmd_byte;
                  4'h5: par_d.size_code = i_cmd_byte[2:0];
                  4'h6: par_d.last_sector_number = i_cmd_byte;
                  4'h7: par_d.gap_len   = i_cmd_byte;
                  4'h8: begin
                     // Same slot, two meanings
                     if (par_q.count_enable) begin
                        par_d.sectors_per_track = i_cmd_byte;
                     end else begin
                        par_d.special_length = i_cmd_byte;
                     end
                  end
                  default: par_d = par_q;
               endcase
            end
            K_FORMAT: begin
               case (idx_q)
                  4'h1: begin
                     par_d.unit = i_cmd_byte[1:0];
                     par_d.head = i_cmd_byte[HEAD_BIT];
                  end
                  4'h2: par_d.size_code         = i_cmd_byte[2:0];
                  4'h3: par_d.sectors_per_track = i_cmd_byte;
                  4'h4: par_d.gap_len           = i_cmd_byte;
                  4'h5: par_d.fill_pattern      = i_cmd_byte;
                  default: par_d = par_q;
               endcase
            end
            K_SEEK, K_REL_SEEK, K_RECAL: begin
               if (idx_q == 4'h1) begin
                  par_d.unit = i_cmd_byte[1:0];
                  par_d.head = i_cmd_byte[HEAD_BIT];
               end else begin
                  par_d.cylinder = i_cmd_byte;
               end
            end
            K_CONFIGURE: begin
               if (idx_q == 4'h2) begin
                  cfg_d.implied_seek_enable = i_cmd_byte[EIS_BIT];
                  cfg_d.queue_enable_n      = i_cmd_byte[QUEUE_ENABLE_N_BIT];
                  cfg_d.fifo_threshold      = i_cmd_byte[THR_MSB:THR_LSB];
               end
            end
            K_PERP: begin
               cfg_d.vertical_drive_flags = i_cmd_byte[PERP_MSB:PERP_LSB];
            end
            default: par_d = par_q;
         endcase
      end
   end

   // Sector data path mode follows the latched command
   assign gate_mode = (kind_q == K_FORMAT) ? M_FORMAT
                    : ((kind_q == K_WRITE) ? M_WRITE : M_READ);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_q        <= PH_COMMAND;
         kind_q         <= K_INVALID;
         idx_q          <= 4'h0;
         need_q         <= NPAR_NONE;
         invalid_pend_q <= 1'b0;
         irq_q          <= 1'b0;
         sense_q        <= ST0_NORMAL;
      end else begin
         phase_q        <= phase_d;
         kind_q         <= kind_d;
         idx_q          <= idx_d;
         need_q         <= need_d;
         invalid_pend_q <= invalid_pend_d;
         irq_q          <= irq_d;
         sense_q        <= sense_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         par_q <= '0;
         cfg_q <= '{queue_enable_n: QUEUE_EN_N_RST,
                    implied_seek_enable: 1'b0,
                    fifo_threshold: THR_RST,
                    vertical_drive_flags: 4'h0};
      end else begin
         par_q <= par_d;
         cfg_q <= cfg_d;
      end
   end

   // Request flag drops for at least one cycle after each byte taken
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rqm_q        <= 1'b0;
         start_q      <= 1'b0;
         seek_first_q <= 1'b0;
         o_transfer_direction_flag <= 1'b0;
         o_cmd_busy                <= 1'b0;
         o_drive_select            <= 4'h1;
      end else begin
         rqm_q   <= !take && ((phase_d == PH_COMMAND) ||
                    ((phase_d == PH_RESULT) && !i_result_done));
         o_transfer_direction_flag <= (phase_d == PH_RESULT);
         o_cmd_busy                <= !((phase_d == PH_COMMAND) && (idx_d == 4'h0));
         o_drive_select            <= unit_onehot(par_d.unit);
         start_q <= cmd_complete && (phase_after_cmd(done_kind) == PH_EXEC);
         if (cmd_complete) begin
            seek_first_q <= cfg_q.implied_seek_enable && has_cyl;
         end
      end
   end

   sector_byte_gate u_gate (
      .i_ref_clk        (i_ref_clk),
      .i_rst_n          (i_rst_n),
      .i_start          (start_q),
      .i_byte_strobe    (i_byte_strobe),
      .i_mode           (gate_mode),
      .i_size_code      (par_q.size_code),
      .i_special_length (par_q.special_length),
      .i_fill_pattern   (par_q.fill_pattern),
      .i_host_byte      (i_host_byte),
      .o_disk_byte      (o_disk_byte),
      .o_host_pass      (o_host_pass),
      .o_crc_take       (o_crc_take),
      .o_sector_end     (o_sector_end)
   );

   assign o_request_for_master      = rqm_q;
   assign o_irq                     = irq_q;
   assign o_exec_start              = start_q;
   assign o_cmd_kind                = kind_q;
   assign o_params                  = par_q;
   assign o_config                  = cfg_q;
   assign o_seek_first              = seek_first_q;
   assign o_sense_status            = sense_q;

endmodule

// >>> tb/disk_host_model.sv
`timescale 1ns/1ps
module disk_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rqm,
   input  wire logic       i_dio,
   output logic            o_wr,
   output logic [7:0]      o_byte
);
   initial begin
      o_wr = 1'b0;
      o_byte = 8'h00;
   end
   // Slow hosts add idle cycles before polling
   task automatic send(input logic [7:0] b, input int slow);
      int n;
      n = 0;
      repeat (slow) @(posedge i_ref_clk);
      @(posedge i_ref_clk);
      while (!(i_rqm === 1'b1 && i_dio === 1'b0) && n < 300) begin
         n++;
         @(posedge i_ref_clk);
      end
      o_wr <= 1'b1;
      o_byte <= b;
      @(posedge i_ref_clk);
      o_wr <= 1'b0;
      o_byte <= ~b; // Idle bus shows junk
   endtask
endmodule

// >>> tb/disk_cmd_assertions.sv
`timescale 1ns/1ps
module disk_cmd_checker
   import disk_cmd_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_cmd_wr,
   input  wire logic [7:0]                  i_cmd_byte,
   input  wire logic                        i_byte_strobe,
   input  wire logic                        o_request_for_master,
   input  wire logic                        o_transfer_direction_flag,
   input  wire logic                        o_cmd_busy,
   input  wire logic                        o_irq,
   input  wire logic                        o_exec_start,
   input  wire disk_cmd_pkg::cmd_params_t   o_params,
   input  wire disk_cmd_pkg::disk_config_t  o_config,
   input  wire logic [3:0]                  o_drive_select,
   input  wire logic                        o_host_pass,
   input  wire logic                        o_crc_take,
   input  wire logic                        o_sector_end
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   wire take = i_cmd_wr && o_request_for_master && !o_transfer_direction_flag;
   wire first = take && !o_cmd_busy;
   wire bad = !(i_cmd_byte[4:0] inside {OP_READ, OP_WRITE, OP_FORMAT, OP_VERIFY, OP_SEEK,
      OP_RECAL, OP_SENSE_INT, OP_SPECIFY, OP_CONFIGURE, OP_PERP});
   a_rqm_drop: assert property (take |=> !o_request_for_master)
      else $error("ready flag stayed up after a byte");
   a_bad_opcode: assert property (first && bad |=> o_irq)
      else $error("bad opcode raised no interrupt");
   a_sense_clear: assert property (first && i_cmd_byte == 8'h08 |=> !o_irq)
      else $error("sense opcode left interrupt up");
   a_unit_decode: assert property (o_drive_select == (4'h1 << o_params.unit))
      else $error("drive select decode wrong");
   a_fields_hold: assert property (!$past(i_cmd_wr) |-> $stable({o_params, o_config}))
      else $error("fields moved without a byte");
   a_crc_each: assert property (i_byte_strobe && o_cmd_busy && !o_request_for_master
      |=> o_crc_take) else $error("sector byte missed by check");
   a_crc_cause: assert property (o_crc_take |-> $past(i_byte_strobe))
      else $error("check pulse without a byte");
   a_pass_inside: assert property (o_host_pass || o_sector_end |-> o_crc_take)
      else $error("host pass outside a sector byte");
   a_exec_quiet: assert property ($rose(o_exec_start) |->
      !o_request_for_master ##1 !o_exec_start) else $error("bad execution entry");
endmodule
bind disk_cmd_param_decoder disk_cmd_checker disk_cmd_checker_i (.*);

// >>> tb/disk_cmd_param_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module disk_cmd_param_decoder_tb_top;
   import disk_cmd_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         x_done = 1'b0;
   logic         r_done = 1'b0;
   logic         stb = 1'b0;
   logic [7:0]   hbyte = 8'h00;
   logic         wr, request_for_master, transfer_direction_flag, busy, irq, x_start, seekf, hpass, crc, s_end;
   logic [7:0]   cbyte, sense, dbyte, cy, ln;
   logic [3:0]   dsel;
   logic [2:0]   sz;
   cmd_kind_t    kind;
   cmd_params_t  prm;
   disk_config_t cfg;
   logic [31:0]  rnd = 32'h0000364f;
   logic [69:0]  e;
   logic [69:0]  expq[$];
   int           errors = 0;
   int           n_tests = 0;
   wire  [34:0]  obs = {kind, dsel, prm.cylinder, prm.step_inward, seekf,
      prm.last_sector_number, prm.count_enable, prm.sectors_per_track};
   always #25 clk = ~clk;
   disk_host_model disk_host_model_i (.i_ref_clk(clk), .i_rqm(request_for_master), .i_dio(transfer_direction_flag),
      .o_wr(wr), .o_byte(cbyte));
   disk_cmd_param_decoder disk_cmd_param_decoder_i (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_cmd_wr(wr), .i_cmd_byte(cbyte), .i_exec_done(x_done), .i_result_done(r_done),
      .i_byte_strobe(stb), .i_host_byte(hbyte), .o_request_for_master(request_for_master),
      .o_transfer_direction_flag(transfer_direction_flag), .o_cmd_busy(busy), .o_irq(irq),
      .o_exec_start(x_start), .o_cmd_kind(kind), .o_params(prm), .o_config(cfg),
      .o_seek_first(seekf), .o_sense_status(sense), .o_drive_select(dsel),
      .o_disk_byte(dbyte), .o_host_pass(hpass), .o_crc_take(crc), .o_sector_end(s_end));
   function automatic logic [31:0] nxt();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) disk_host_model_i.send(q[i], i % 3);
   endtask
   task automatic r_pulse();
      r_done <= 1'b1;
      tick(1);
      r_done <= 1'b0;
      tick(2);
   endtask
   task automatic pulse_end(input bit res);
      tick(3);
      x_done <= 1'b1;
      tick(1);
      x_done <= 1'b0;
      tick(2);
      if (res) r_pulse();
   endtask
   // One strobe every other cycle; outputs land one cycle after each strobe
   task automatic sect(input int n, input int lim, input logic [7:0] pad, input bit dchk,
                       input int want);
      int c, p, s;
      logic [7:0] hb;
      c = 0;
      p = 0;
      s = 0;
      for (int i = 0; i < n; i++) begin
         void'(nxt());
         hb = rnd[7:0];
         stb <= 1'b1;
         hbyte <= hb;
         tick(1);
         stb <= 1'b0;
         hbyte <= ~hb;
         tick(1);
         c += (crc === 1'b1);
         p += (hpass === 1'b1);
         s += (s_end === 1'b1);
         if (dchk) `CHK(dbyte, (i < lim) ? hb : pad)
      end
      `CHK(c, n)
      if (want >= 0) `CHK(p, want)
      `CHK(s, 1)
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Each entry into execution retires the oldest note
   always @(posedge clk) begin
      if (x_start === 1'b1) begin
         e = (expq.size() > 0) ? expq.pop_front() : '1;
         `CHK(obs & e[34:0], e[69:35] & e[34:0])
      end
   end
   // Whole run needs under two thousand cycles
   initial begin
      tick(30000);
      errors++;
      finish_test();
   end
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(2);
      `CHK(cfg.queue_enable_n, 1'b1)
      `CHK(dsel, 4'h1)
      for (int u = 0; u < 8; u++) begin
         void'(nxt());
         cy = (u == 0) ? 8'h00 : (u == 3) ? 8'hff : rnd[7:0];
         if (u < 4) begin
            expq.push_back({K_SEEK, 4'h1 << u[1:0], cy, 19'h0, 16'hffff, 19'h0});
            send('{8'h0f, {6'h0, u[1:0]}, cy});
         end else begin
            expq.push_back({K_REL_SEEK, 4'h1, cy, u[0], 18'h0, 17'h1fe01, 18'h0});
            send('{{1'b1, u[0], 6'h0f}, 8'h00, cy});
         end
         pulse_end(1'b0);
      end
      $display("test seek done");
      for (int k = 0; k < 2; k++) begin
         if (k == 1) send('{8'h1f});
         tick(2);
         `CHK(irq, 1'b1)
         send('{8'h08});
         tick(2);
         `CHK(irq, 1'b0)
         `CHK(sense, k ? ST0_INVALID : ST0_NORMAL)
         r_pulse();
      end
      $display("test sense done");
      void'(nxt());
      send('{8'h13, 8'h00, 8'h40, 8'h00});
      send('{8'h12, {2'h0, rnd[3:0], 2'h0}});
      tick(2);
      `CHK(cfg.queue_enable_n, 1'b0)
      `CHK(cfg.implied_seek_enable, 1'b1)
      `CHK(cfg.vertical_drive_flags, rnd[3:0])
      $display("test config done");
      for (int k = 0; k < 4; k++) begin
         void'(nxt());
         ln = {1'b0, rnd[6:0]} | 8'h01;
         sz = (k == 1) ? 3'h1 : 3'h0;
         if (k < 3) begin
            expq.push_back({(k < 2) ? K_READ : K_WRITE, 4'h1 << rnd[25:24], rnd[15:8],
               2'b01, rnd[23:16], 9'h0, 16'hffff, 2'b01, 8'hff, 9'h0});
            send('{(k < 2) ? 8'h06 : 8'h05, {6'h0, rnd[25:24]}, rnd[15:8], 8'h00, 8'h01,
               {5'h0, sz}, rnd[23:16], 8'h1b, ln});
         end else begin
            expq.push_back({K_FORMAT, 31'h0, 4'hf, 31'h0});
            send('{8'h0d, {6'h0, rnd[25:24]}, 8'h00, 8'h08, 8'h1b, rnd[31:24]});
         end
         tick(4);
         sect(128 << sz, (k == 3) ? 0 : ln, (k == 3) ? rnd[31:24] : 8'h00, k >= 2,
              (k == 0) ? ln : (k == 1) ? 256 : -1);
         pulse_end(1'b1);
      end
      $display("test sector done");
      void'(nxt());
      expq.push_back({K_VERIFY, 4'h1 << rnd[1:0], rnd[15:8], 10'h0, 1'b1, rnd[23:16],
         16'hffff, 10'h0, 9'h1ff});
      send('{8'h16, {1'b1, 5'h0, rnd[1:0]}, rnd[15:8], 8'h00, 8'h01, 8'h00, 8'h12, 8'h1b,
         rnd[23:16]});
      pulse_end(1'b1);
      $display("test verify done");
      finish_test();
   end
endmodule
